// file: core/qd_pkg.sv
// Constants, register map and helper functions of the quadrature decoder.
// Assumes one clock domain and a 32-bit AXI4-Lite register port.
package qd_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] CFG1_IDX = 16'ha070;
    localparam logic [15:0] CFG2_IDX = 16'ha071;
    localparam logic [15:0] CFG3_IDX = 16'ha072;
    localparam logic [15:0] CNTL_IDX = 16'ha074;
    localparam logic [15:0] CNTH_IDX = 16'ha075;
    localparam logic [15:0] MAXL_IDX = 16'ha076;
    localparam logic [15:0] MAXH_IDX = 16'ha077;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // Config one fields
    localparam int MODE_LSB = 6;
    localparam int SAMPLE_CLOCK_SCALE_LSB = 4;
    localparam int SWAP_BIT = 3;
    localparam int DEBOUNCE_SCALE_LSB = 0;
    // Status fields
    localparam int DIR_BIT = 7;
    localparam int PHASE_ERROR_FLAG_BIT = 6;
    localparam int RELOAD_MODE_LSB = 4;
    localparam int TCF_BIT = 3;
    localparam int INDEX_EVENT_FLAG_BIT = 2;
    localparam int DIRECTION_CHANGE_FLAG_BIT = 1;
    localparam int COUNT_CHANGE_FLAG_BIT = 0;
    // Config three fields
    localparam int IEN_LSB = 3;
    localparam int INDEX_INPUT_GATE_BIT = 2;
    localparam int INDEX_MATCH_SEL_LSB = 0;

    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_X1 = 2'h1;
    localparam logic [1:0] MODE_X2 = 2'h2;
    localparam logic [1:0] MODE_X4 = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Next phase state when turning up: 00, 10, 11, 01
    function automatic logic [1:0] qd_gray_up(input logic [1:0] s);
        case (s)
            2'h0: qd_gray_up = 2'h2;
            2'h2: qd_gray_up = 2'h3;
            2'h3: qd_gray_up = 2'h1;
            default: qd_gray_up = 2'h0;
        endcase
    endfunction

    // Index qualifying up transition {from, to}
    function automatic logic [3:0] qd_idx_pair(input logic [1:0] sel);
        case (sel)
            2'h0: qd_idx_pair = 4'h2;
            2'h1: qd_idx_pair = 4'hb;
            2'h2: qd_idx_pair = 4'h4;
            default: qd_idx_pair = 4'hd;
        endcase
    endfunction

    // Tick masks, period is mask plus one
    function automatic logic [7:0] qd_sample_mask(input logic [1:0] code);
        case (code)
            2'h0: qd_sample_mask = 8'h03;
            2'h1: qd_sample_mask = 8'h0f;
            2'h2: qd_sample_mask = 8'h3f;
            default: qd_sample_mask = 8'hff;
        endcase
    endfunction

    function automatic logic [7:0] qd_db_mask(input logic [2:0] code);
        case (code)
            3'h1: qd_db_mask = 8'h01;
            3'h2: qd_db_mask = 8'h03;
            3'h3: qd_db_mask = 8'h07;
            3'h4: qd_db_mask = 8'h0f;
            3'h5: qd_db_mask = 8'h3f;
            3'h6: qd_db_mask = 8'h7f;
            default: qd_db_mask = 8'hff;
        endcase
    endfunction

endpackage

// file: core/qd_tick.sv
// Free running divider giving a one-cycle tick every mask+1 clocks.
// Assumes the mask is a run of low ones.
`timescale 1ns/1ps
`default_nettype none
module qd_tick #(
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CNT_W-1:0] div_mask,
    output logic tick_q
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= (cnt_q & div_mask) == div_mask;
        end
    end
endmodule // qd_tick
`default_nettype wire

// file: core/qd_debounce.sv
// Pin synchroniser and three-sample debounce filter.
// Assumes raw inputs are asynchronous pins; tick comes from qd_tick.
`timescale 1ns/1ps
`default_nettype none
module qd_debounce #(
    parameter int N = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] raw_in,
    input wire logic tick,
    input wire logic bypass,
    output logic [N-1:0] clean_q
);
    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] hist1_q;
    logic [N-1:0] hist2_q;
    logic [N-1:0] agree1;
    logic [N-1:0] agree0;

    assign agree1 = sync2_q & hist1_q & hist2_q;
    assign agree0 = ~(sync2_q | hist1_q | hist2_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist1_q <= '0;
            hist2_q <= '0;
            clean_q <= '0;
        end else if (bypass) begin
            hist1_q <= sync2_q;
            hist2_q <= sync2_q;
            clean_q <= sync2_q;
        end else if (tick) begin
            hist1_q <= sync2_q;
            hist2_q <= hist1_q;
            clean_q <= (clean_q & ~agree0) | agree1;
        end
    end
endmodule // qd_debounce
`default_nettype wire

// file: core/qd_top.sv
// Quadrature decoder with position counter and AXI4-Lite registers.
// Assumes phase and index pins are asynchronous to aclk.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module qd_top #(
    parameter int ADDR_W = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    output logic irq_req_q,
    output logic tc_event_q,
    output logic index_event_q
);
    // Bus state
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic do_wr;
    logic wr_hit;
    logic [15:0] wr_idx;

    // Registers
    logic [1:0] decode_resolution_sel_q;
    logic [1:0] sample_clock_scale_q;
    logic swap_q;
    logic [2:0] debounce_scale_q;
    logic [1:0] reload_mode_q;
    logic [4:0] irq_en_q;
    logic index_input_gate_q;
    logic [1:0] index_match_sel_q;
    logic [15:0] position_counter_q;
    logic [15:0] position_counter_d;
    logic [15:0] position_limit_q;
    logic dir_q;
    logic phase_error_flag_q;
    logic terminal_count_flag_q;
    logic index_event_flag_q;
    logic direction_change_flag_q;
    logic count_change_flag_q;

    // Decoder
    logic [2:0] pins_clean;
    logic db_tick;
    logic smp_tick;
    logic [1:0] prev_q;
    logic [1:0] cur;
    logic [3:0] idx_pair;
    logic enabled;
    logic up_t;
    logic dn_t;
    logic both_chg;
    logic step;
    logic idx_ev;
    logic idx_gated;
    logic tc_ev;
    logic reload;
    logic [15:0] reload_val;

    // Write strobes
    logic wr_cfg1;
    logic wr_cfg2;
    logic wr_cfg3;
    logic wr_cntl;
    logic wr_cnth;
    logic wr_maxl;
    logic wr_maxh;

    qd_tick #(
        .CNT_W(8)
    ) u_db_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .div_mask(qd_pkg::qd_db_mask(debounce_scale_q)),
        .tick_q(db_tick)
    );

    qd_tick #(
        .CNT_W(8)
    ) u_smp_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .div_mask(qd_pkg::qd_sample_mask(sample_clock_scale_q)),
        .tick_q(smp_tick)
    );

    qd_debounce #(
        .N(3)
    ) u_debounce (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw_in({index_input, phase_a_input, phase_b_input}),
        .tick(db_tick),
        .bypass(debounce_scale_q == 3'h0),
        .clean_q(pins_clean)
    );

    // Phase decode
    assign enabled = decode_resolution_sel_q != qd_pkg::MODE_OFF;
    assign cur = swap_q ? {pins_clean[0], pins_clean[1]} : pins_clean[1:0];
    assign idx_gated = pins_clean[2] & index_input_gate_q;
    assign up_t = cur == qd_pkg::qd_gray_up(prev_q);
    assign dn_t = prev_q == qd_pkg::qd_gray_up(cur);
    assign both_chg = &(cur ^ prev_q);
    assign idx_pair = qd_pkg::qd_idx_pair(index_match_sel_q);

    always_comb begin
        step = 1'b0;
        case (decode_resolution_sel_q)
            qd_pkg::MODE_X1: step = (up_t && prev_q == 2'h0) || (dn_t && cur == 2'h0);
            qd_pkg::MODE_X2: step = (up_t || dn_t) && (cur[1] != prev_q[1]);
            qd_pkg::MODE_X4: step = up_t || dn_t;
            default: step = 1'b0;
        endcase
        step = step && enabled && smp_tick;
    end

    always_comb begin
        idx_ev = 1'b0;
        if (decode_resolution_sel_q == qd_pkg::MODE_X1) begin
            idx_ev = step;
        end else if (up_t) begin
            idx_ev = prev_q == idx_pair[3:2] && cur == idx_pair[1:0];
        end else if (dn_t) begin
            idx_ev = prev_q == idx_pair[1:0] && cur == idx_pair[3:2];
        end
        idx_ev = idx_ev && idx_gated && enabled && smp_tick;
    end

    // Terminal count on a step from max going up or from zero going down
    assign tc_ev = step && (up_t ? position_counter_q == position_limit_q
                                 : position_counter_q == 16'h0000);
    assign reload_val = up_t ? 16'h0000 : position_limit_q;
    assign reload = (idx_ev && reload_mode_q[0]) || (tc_ev && reload_mode_q[1]);

    always_comb begin
        position_counter_d = position_counter_q;
        if (reload) begin
            position_counter_d = reload_val;
        end else if (step) begin
            position_counter_d = up_t ? position_counter_q + 16'h0001
                                      : position_counter_q - 16'h0001;
        end
    end

    // Write decode
    assign wr_idx = awaddr_q[17:2];
    assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = (awaddr_q >> 18) == '0 && awaddr_q[1:0] == 2'h0
        && (wr_idx == qd_pkg::CFG1_IDX || wr_idx == qd_pkg::CFG2_IDX
        || wr_idx == qd_pkg::CFG3_IDX || wr_idx == qd_pkg::CNTL_IDX
        || wr_idx == qd_pkg::CNTH_IDX || wr_idx == qd_pkg::MAXL_IDX
        || wr_idx == qd_pkg::MAXH_IDX);
    assign wr_cfg1 = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::CFG1_IDX;
    assign wr_cfg2 = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::CFG2_IDX;
    assign wr_cfg3 = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::CFG3_IDX;
    assign wr_cntl = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::CNTL_IDX;
    assign wr_cnth = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::CNTH_IDX;
    assign wr_maxl = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::MAXL_IDX;
    assign wr_maxh = do_wr && wlane_q && wr_hit && wr_idx == qd_pkg::MAXH_IDX;

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= qd_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wbyte_q <= qd_pkg::REG_RESET;
            wlane_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? qd_pkg::RESP_OKAY : qd_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= qd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= qd_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if ((s_axi_araddr >> 18) != '0 || s_axi_araddr[1:0] != 2'h0) begin
                s_axi_rresp <= qd_pkg::RESP_SLVERR;
            end else begin
                case (s_axi_araddr[17:2])
                    qd_pkg::CFG1_IDX: s_axi_rdata[7:0] <= {decode_resolution_sel_q,
                        sample_clock_scale_q, swap_q, debounce_scale_q};
                    qd_pkg::CFG2_IDX: s_axi_rdata[7:0] <= {dir_q, phase_error_flag_q,
                        reload_mode_q, terminal_count_flag_q, index_event_flag_q,
                        direction_change_flag_q, count_change_flag_q};
                    qd_pkg::CFG3_IDX: s_axi_rdata[7:0] <= {irq_en_q, index_input_gate_q,
                        index_match_sel_q};
                    qd_pkg::CNTL_IDX: s_axi_rdata[7:0] <= position_counter_q[7:0];
                    qd_pkg::CNTH_IDX: s_axi_rdata[7:0] <= position_counter_q[15:8];
                    qd_pkg::MAXL_IDX: s_axi_rdata[7:0] <= position_limit_q[7:0];
                    qd_pkg::MAXH_IDX: s_axi_rdata[7:0] <= position_limit_q[15:8];
                    default: s_axi_rresp <= qd_pkg::RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            decode_resolution_sel_q <= 2'h0;
            sample_clock_scale_q <= 2'h0;
            swap_q <= 1'b0;
            debounce_scale_q <= 3'h0;
            reload_mode_q <= 2'h0;
            irq_en_q <= 5'h00;
            index_input_gate_q <= 1'b0;
            index_match_sel_q <= 2'h0;
        end else begin
            if (wr_cfg1) begin
                decode_resolution_sel_q <= wbyte_q[qd_pkg::MODE_LSB +: 2];
                sample_clock_scale_q <= wbyte_q[qd_pkg::SAMPLE_CLOCK_SCALE_LSB +: 2];
                swap_q <= wbyte_q[qd_pkg::SWAP_BIT];
                debounce_scale_q <= wbyte_q[qd_pkg::DEBOUNCE_SCALE_LSB +: 3];
            end
            if (wr_cfg2) begin
                reload_mode_q <= wbyte_q[qd_pkg::RELOAD_MODE_LSB +: 2];
            end
            if (wr_cfg3) begin
                irq_en_q <= wbyte_q[qd_pkg::IEN_LSB +: 5];
                index_input_gate_q <= wbyte_q[qd_pkg::INDEX_INPUT_GATE_BIT];
                index_match_sel_q <= wbyte_q[qd_pkg::INDEX_MATCH_SEL_LSB +: 2];
            end
        end
    end

    // Limit register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position_limit_q <= qd_pkg::CNT_RESET;
        end else begin
            if (wr_maxl) begin
                position_limit_q[7:0] <= wbyte_q;
            end
            if (wr_maxh) begin
                position_limit_q[15:8] <= wbyte_q;
            end
        end
    end

    // Position counter; a software load overrides a decoder step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position_counter_q <= qd_pkg::CNT_RESET;
        end else if (wr_cntl) begin
            position_counter_q[7:0] <= wbyte_q;
        end else if (wr_cnth) begin
            position_counter_q[15:8] <= wbyte_q;
        end else begin
            position_counter_q <= position_counter_d;
        end
    end

    // Phase history and direction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 2'h0;
            dir_q <= 1'b0;
        end else begin
            if (smp_tick) begin
                prev_q <= cur;
            end
            if (step) begin
                dir_q <= up_t;
            end
        end
    end

    // Event flags: hardware set wins over a write of zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_error_flag_q <= 1'b0;
            terminal_count_flag_q <= 1'b0;
            index_event_flag_q <= 1'b0;
            direction_change_flag_q <= 1'b0;
            count_change_flag_q <= 1'b0;
        end else begin
            phase_error_flag_q <= (phase_error_flag_q
                && !(wr_cfg2 && !wbyte_q[qd_pkg::PHASE_ERROR_FLAG_BIT]))
                || (enabled && smp_tick && both_chg);
            terminal_count_flag_q <= (terminal_count_flag_q
                && !(wr_cfg2 && !wbyte_q[qd_pkg::TCF_BIT])) || tc_ev;
            index_event_flag_q <= (index_event_flag_q
                && !(wr_cfg2 && !wbyte_q[qd_pkg::INDEX_EVENT_FLAG_BIT])) || idx_ev;
            direction_change_flag_q <= (direction_change_flag_q
                && !(wr_cfg2 && !wbyte_q[qd_pkg::DIRECTION_CHANGE_FLAG_BIT]))
                || (step && up_t != dir_q);
            count_change_flag_q <= (count_change_flag_q
                && !(wr_cfg2 && !wbyte_q[qd_pkg::COUNT_CHANGE_FLAG_BIT]))
                || (position_counter_d != position_counter_q);
        end
    end

    // Interrupt request and event pulses for a capture unit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req_q <= 1'b0;
            tc_event_q <= 1'b0;
            index_event_q <= 1'b0;
        end else begin
            irq_req_q <= |(irq_en_q & {terminal_count_flag_q, index_event_flag_q,
                direction_change_flag_q, count_change_flag_q,
                phase_error_flag_q});
            tc_event_q <= tc_ev;
            index_event_q <= idx_ev;
        end
    end

endmodule // qd_top
`default_nettype wire

// file: tb/qd_top_assertions.sv
// Bus and event timing checks on the quadrature decoder top ports.
// Assumes a bind to qd_top and one aclk domain.
`timescale 1ns/1ps
`default_nettype none
module qd_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_req_q,
    input wire logic tc_event_q,
    input wire logic index_event_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RESET_IDLE: assert property (
        $rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_rvalid && !irq_req_q)
        else $error("Port not idle after reset");
    AST_WR_ANSWER: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("Write response late");
    AST_AW_BUSY: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("Address accepted twice");
    AST_WR_DONE: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("Write channel not restored");
    AST_RD_ANSWER: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read data late");
    AST_RD_DONE: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("Read channel not restored");
    AST_RD_BYTE: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("Upper read bits set");
    AST_TC_PULSE: assert property (
        tc_event_q |=> !tc_event_q [*3])
        else $error("Terminal event too long");
    AST_IDX_PULSE: assert property (
        $rose(index_event_q) |=> $fell(index_event_q))
        else $error("Index event too long");
endmodule // qd_checker

bind qd_top qd_checker u_qd_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .irq_req_q, .tc_event_q, .index_event_q
);
`default_nettype wire

// file: tb/qd_enc_model.sv
// Behavioural quadrature encoder with index output.
// Assumes the bench spaces steps wider than the decoder sampling.
`timescale 1ns/1ps
`default_nettype none
module qd_enc_model (
    input wire logic aclk,
    input wire logic step_en,
    input wire logic step_up,
    input wire logic glitch,
    input wire logic index_req,
    output logic phase_a,
    output logic phase_b,
    output logic index_pin
);
    logic [1:0] pos_q = 2'h0;
    // Order 00,10,11,01 going up; glitch flips both at once
    always @(posedge aclk) begin
        if (glitch) begin
            pos_q <= ~pos_q;
        end else if (step_en) begin
            pos_q <= step_up ? {~pos_q[0], pos_q[1]} : {pos_q[0], ~pos_q[1]};
        end
    end
    assign phase_a = pos_q[1];
    assign phase_b = pos_q[0];
    assign index_pin = index_req;
endmodule // qd_enc_model
`default_nettype wire

// file: tb/quadrature_decoder_test.sv
// Self-checking bench for the quadrature decoder top.
// Assumes the encoder model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module quadrature_decoder_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic phase_a_input, phase_b_input, index_input, irq_req_q, tc_event_q, index_event_q;
    logic step_en = 1'b0, step_up = 1'b0, glitch = 1'b0, index_req = 1'b0;
    int n_errors = 0, checks_done = 0;

    initial forever #2.5 aclk = ~aclk;

    qd_top DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .phase_a_input, .phase_b_input, .index_input,
        .irq_req_q, .tc_event_q, .index_event_q
    );
    qd_enc_model u_enc (
        .aclk, .step_en, .step_up, .glitch, .index_req,
        .phase_a(phase_a_input), .phase_b(phase_b_input), .index_pin(index_input)
    );

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang(input bit done);
        chk(34'(done), 34'(1'b1));
        if (!done) print_verdict();
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                      input logic [1:0] er = qd_pkg::RESP_OKAY);
        bit done = 0;
        logic [1:0] resp = '0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
            resp = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
        hang(done);
        chk(34'(resp), 34'(er));
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e,
                      input logic [1:0] er = qd_pkg::RESP_OKAY);
        bit done = 0;
        logic [33:0] got;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
            got = {s_axi_rresp, s_axi_rdata};
        end
        s_axi_rready <= 1'b0;
        hang(done);
        chk(got, {er, 24'h00_0000, e});
    endtask

    // Encoder steps spaced beyond sync, filter and sample tick
    task automatic mv(input logic up, input int cnt, input logic g = 1'b0);
        repeat (cnt) begin
            @(posedge aclk);
            step_en <= ~g;
            step_up <= up;
            glitch <= g;
            @(posedge aclk);
            step_en <= 1'b0;
            glitch <= 1'b0;
            repeat (14) @(posedge aclk);
        end
    endtask

    task automatic irq_is(input logic b);
        repeat (2) @(posedge aclk);
        chk(34'(irq_req_q), 34'(b));
    endtask

    task automatic t_reset();
        wr(16'ha073, 8'h5a, qd_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            rd(16'ha070 + 16'(i), 8'h00,
               i == 3 ? qd_pkg::RESP_SLVERR : qd_pkg::RESP_OKAY);
        end
        $display("t_reset done at %0t", $time);
    endtask

    task automatic t_regs();
        wr(qd_pkg::MAXL_IDX, 8'h34);
        wr(qd_pkg::MAXH_IDX, 8'h12);
        rd(qd_pkg::MAXL_IDX, 8'h34);
        rd(qd_pkg::MAXH_IDX, 8'h12);
        wr(qd_pkg::CNTL_IDX, 8'hfe);
        wr(qd_pkg::CNTH_IDX, 8'hff);
        rd(qd_pkg::CNTL_IDX, 8'hfe);
        rd(qd_pkg::CNTH_IDX, 8'hff);
        $display("t_regs done at %0t", $time);
    endtask

    task automatic t_wrap();
        wr(qd_pkg::CFG1_IDX, 8'hc1);
        mv(1'b1, 3);
        rd(qd_pkg::CNTL_IDX, 8'h01);
        rd(qd_pkg::CNTH_IDX, 8'h00);
        wr(qd_pkg::CFG2_IDX, 8'h00);
        rd(qd_pkg::CFG2_IDX, 8'h80);
        mv(1'b0, 1);
        rd(qd_pkg::CFG2_IDX, 8'h03);
        rd(qd_pkg::CNTL_IDX, 8'h00);
        $display("t_wrap done at %0t", $time);
    endtask

    task automatic t_error();
        wr(qd_pkg::CFG2_IDX, 8'h00);
        mv(1'b0, 1, 1'b1);
        rd(qd_pkg::CFG2_IDX, 8'h40);
        irq_is(1'b0);
        wr(qd_pkg::CFG3_IDX, 8'h08);
        irq_is(1'b1);
        wr(qd_pkg::CFG2_IDX, 8'h00);
        irq_is(1'b0);
        wr(qd_pkg::CFG3_IDX, 8'h00);
        $display("t_error done at %0t", $time);
    endtask

    task automatic t_tc();
        wr(qd_pkg::MAXL_IDX, 8'h02);
        wr(qd_pkg::MAXH_IDX, 8'h00);
        wr(qd_pkg::CFG2_IDX, 8'h20);
        mv(1'b1, 3);
        rd(qd_pkg::CNTL_IDX, 8'h00);
        rd(qd_pkg::CFG2_IDX, 8'hab);
        wr(qd_pkg::CFG2_IDX, 8'h20);
        mv(1'b0, 1);
        rd(qd_pkg::CNTL_IDX, 8'h02);
        rd(qd_pkg::CFG2_IDX, 8'h2b);
        $display("t_tc done at %0t", $time);
    endtask

    task automatic t_index();
        wr(qd_pkg::CFG2_IDX, 8'h10);
        mv(1'b1, 2);
        wr(qd_pkg::CFG2_IDX, 8'h10);
        index_req <= 1'b1;
        mv(1'b1, 1);
        rd(qd_pkg::CFG2_IDX, 8'h91);
        wr(qd_pkg::CFG3_IDX, 8'h05);
        mv(1'b1, 1);
        rd(qd_pkg::CNTL_IDX, 8'h00);
        rd(qd_pkg::CFG2_IDX, 8'h95);
        index_req <= 1'b0;
        $display("t_index done at %0t", $time);
    endtask

    task automatic t_modes();
        wr(qd_pkg::CFG1_IDX, 8'h88);
        mv(1'b1, 2);
        rd(qd_pkg::CNTL_IDX, 8'hff);
        wr(qd_pkg::CFG1_IDX, 8'h00);
        mv(1'b1, 1);
        rd(qd_pkg::CNTL_IDX, 8'hff);
        wr(qd_pkg::CFG1_IDX, 8'h40);
        mv(1'b1, 4);
        rd(qd_pkg::CNTL_IDX, 8'h00);
        $display("t_modes done at %0t", $time);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_regs();
        t_wrap();
        t_error();
        t_tc();
        t_index();
        t_modes();
        print_verdict();
    end
endmodule // quadrature_decoder_test
`default_nettype wire
